//--- hdl/ecg_lock_watch.sv
`timescale 1ns/1ns
`default_nettype none

module ecg_lock_watch
  import ecg_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pll_locked,
  input wire logic power_enable,
  input wire logic clear_on_read,
  output logic lock_lost,
  output logic lost_event
);

  // ==================================================================
  // State
  typedef struct packed {
    logic armed;
    logic prev_lock;
    logic lost;
    logic event_pulse;
  } ecg_lw_state_t;

  ecg_lw_state_t st_r;
  ecg_lw_state_t st_nxt;
  logic fall;

  // ==================================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // A fall only counts once the enabled PLL has locked
    fall = st_r.armed && st_r.prev_lock && !pll_locked;
    st_nxt.prev_lock = pll_locked;
    st_nxt.armed = power_enable && (st_r.armed || pll_locked);
    st_nxt.event_pulse = fall;
    if (!power_enable) begin
      st_nxt.lost = 1'b0;
    end else if (fall) begin
      st_nxt.lost = 1'b1;
    end else if (clear_on_read) begin
      st_nxt.lost = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lock_lost = st_r.lost;
  assign lost_event = st_r.event_pulse;

endmodule // ecg_lock_watch

`default_nettype wire

//--- hdl/ecg_status_pkg.sv
package ecg_status_pkg;

  // ==================================================================
  // Register indices; byte address is four times the index
  localparam int ECG_ADDR_W = 8;
  localparam logic [5:0] ECG_IDX_CTRL = 6'h01;
  localparam logic [5:0] ECG_IDX_RANGE_FLAGS = 6'h1e;
  localparam logic [5:0] ECG_IDX_OPSTATE = 6'h1f;
  localparam logic [5:0] ECG_IDX_IRQ_STATUS = 6'h30;
  localparam logic [5:0] ECG_IDX_IRQ_MASK = 6'h31;

  // ==================================================================
  // Field layout
  localparam int ECG_REG_W = 24;
  localparam int ECG_NUM_ELECTRODES = 7;
  // Index 0 common, 1 chest two, 2 chest one, 3 right arm, 4 left leg, 5 left arm, 6 right leg drive
  localparam int ECG_OVER_POS [ECG_NUM_ELECTRODES] = '{13, 18, 19, 20, 21, 22, 23};
  localparam int ECG_UNDER_POS [ECG_NUM_ELECTRODES] = '{2, 7, 8, 9, 10, 11, 12};
  localparam int ECG_POWER_ENABLE_POS = 1;
  localparam int ECG_OPS_LOCK_NOW = 0;
  localparam int ECG_OPS_LOCK_LOST = 1;
  localparam int ECG_OPS_BUSY = 2;
  localparam int ECG_OPS_INT_FAULT = 3;
  localparam int ECG_IRQ_W = 4;
  localparam int ECG_IRQ_LOCK_LOST = 0;
  localparam int ECG_IRQ_INT_FAULT = 1;
  localparam int ECG_IRQ_CFG_READY = 2;
  localparam int ECG_IRQ_LEAD_OFF = 3;

  // ==================================================================
  // Reset values
  localparam logic [23:0] ECG_OPSTATE_RESET = 24'h000001;
  localparam logic [23:0] ECG_CTRL_RESET = 24'h000000;
  localparam logic [ECG_IRQ_W-1:0] ECG_IRQ_MASK_RESET = 4'h0;

  // ==================================================================
  // AXI responses
  localparam logic [1:0] ECG_RESP_OKAY = 2'h0;
  localparam logic [1:0] ECG_RESP_SLVERR = 2'h2;

endpackage

//--- hdl/ecg_status_regs.sv
`timescale 1ns/1ns
`default_nettype none

module ecg_status_regs
  import ecg_status_pkg::*;
#(
  parameter int NUM_ELECTRODES = ECG_NUM_ELECTRODES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ECG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ECG_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_ELECTRODES-1:0] over_cmp,
  input wire logic [NUM_ELECTRODES-1:0] under_cmp,
  input wire logic pll_locked,
  input wire logic internal_error,
  input wire logic config_loaded,
  output logic power_enable_bit,
  output logic irq
);

  // ==================================================================
  // State
  typedef struct packed {
    logic aw_held;
    logic [ECG_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic power_enable;
    logic [ECG_REG_W-1:0] range_flags;
    logic lock_now;
    logic busy;
    logic int_fault;
    logic [ECG_IRQ_W-1:0] irq_status;
    logic [ECG_IRQ_W-1:0] irq_mask;
    logic irq;
  } ecg_state_t;

  ecg_state_t st_r;
  ecg_state_t st_nxt;

  logic lock_lost;
  logic lost_event;
  logic rd_take;
  logic rd_opstate;
  logic aw_have;
  logic w_have;
  logic [ECG_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [ECG_REG_W-1:0] flags_now;
  logic [ECG_REG_W-1:0] opstate_word;
  logic [ECG_IRQ_W-1:0] irq_set;
  logic [ECG_IRQ_W-1:0] irq_clr;

  // ==================================================================
  // Word assembly
  function automatic logic [ECG_REG_W-1:0] pack_flags(
    input logic [NUM_ELECTRODES-1:0] over,
    input logic [NUM_ELECTRODES-1:0] under
  );
    logic [ECG_REG_W-1:0] word;
    word = '0;
    for (int i = 0; i < NUM_ELECTRODES; i++) begin
      word[ECG_OVER_POS[i]] = over[i];
      word[ECG_UNDER_POS[i]] = under[i];
    end
    return word;
  endfunction

  function automatic logic mapped(input logic [ECG_ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[ECG_ADDR_W-1:2];
    return (idx == ECG_IDX_CTRL) || (idx == ECG_IDX_RANGE_FLAGS) || (idx == ECG_IDX_OPSTATE) ||
           (idx == ECG_IDX_IRQ_STATUS) || (idx == ECG_IDX_IRQ_MASK);
  endfunction

  // ==================================================================
  // Lock-loss tracking
  // Read of the state word clears the sticky loss bit on the same edge that takes the read
  assign rd_take = s_axi_arvalid && st_r.arready;
  assign rd_opstate = rd_take && (s_axi_araddr[ECG_ADDR_W-1:2] == ECG_IDX_OPSTATE);

  ecg_lock_watch u_lock_watch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pll_locked(pll_locked),
    .power_enable(st_r.power_enable),
    .clear_on_read(rd_opstate),
    .lock_lost(lock_lost),
    .lost_event(lost_event)
  );

  // ==================================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    irq_set = '0;
    irq_clr = '0;

    // Comparators are sampled every cycle; flags are live, not sticky
    flags_now = pack_flags(over_cmp, under_cmp);
    st_nxt.range_flags = flags_now;

    opstate_word = '0;
    opstate_word[ECG_OPS_LOCK_NOW] = st_r.lock_now;
    opstate_word[ECG_OPS_LOCK_LOST] = lock_lost;
    opstate_word[ECG_OPS_BUSY] = st_r.busy;
    opstate_word[ECG_OPS_INT_FAULT] = st_r.int_fault;

    st_nxt.lock_now = pll_locked;
    st_nxt.busy = !config_loaded;
    // Fault stays up until reset so a transient error is not missed by a later read
    if (internal_error) begin
      st_nxt.int_fault = 1'b1;
    end

    // Interrupt events
    irq_set[ECG_IRQ_LOCK_LOST] = lost_event;
    irq_set[ECG_IRQ_INT_FAULT] = internal_error;
    irq_set[ECG_IRQ_CFG_READY] = st_r.busy && config_loaded;
    irq_set[ECG_IRQ_LEAD_OFF] = |(flags_now & ~st_r.range_flags);

    // Write channel
    aw_have = st_r.aw_held || (s_axi_awvalid && st_r.awready);
    w_have = st_r.w_held || (s_axi_wvalid && st_r.wready);
    wr_addr = st_r.aw_held ? st_r.aw_addr : s_axi_awaddr;
    wr_data = st_r.w_held ? st_r.w_data : s_axi_wdata;
    wr_strb = st_r.w_held ? st_r.w_strb : s_axi_wstrb;
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (aw_have && w_have && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(wr_addr) ? ECG_RESP_OKAY : ECG_RESP_SLVERR;
      // Status words are read-only; writes to them are accepted and dropped
      unique case (wr_addr[ECG_ADDR_W-1:2])
        ECG_IDX_CTRL: begin
          if (wr_strb[0]) begin
            st_nxt.power_enable = wr_data[ECG_POWER_ENABLE_POS];
          end
        end
        ECG_IDX_IRQ_STATUS: begin
          if (wr_strb[0]) begin
            irq_clr = wr_data[ECG_IRQ_W-1:0];
          end
        end
        ECG_IDX_IRQ_MASK: begin
          if (wr_strb[0]) begin
            st_nxt.irq_mask = wr_data[ECG_IRQ_W-1:0];
          end
        end
        default: begin
          st_nxt.bresp = st_nxt.bresp;
        end
      endcase
    end
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

    // Read channel; status reaches software only here, never a stream
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = mapped(s_axi_araddr) ? ECG_RESP_OKAY : ECG_RESP_SLVERR;
      st_nxt.rdata = '0;
      unique case (s_axi_araddr[ECG_ADDR_W-1:2])
        ECG_IDX_CTRL: begin
          st_nxt.rdata[ECG_POWER_ENABLE_POS] = st_r.power_enable;
        end
        ECG_IDX_RANGE_FLAGS: begin
          st_nxt.rdata[ECG_REG_W-1:0] = st_r.range_flags;
        end
        ECG_IDX_OPSTATE: begin
          st_nxt.rdata[ECG_REG_W-1:0] = opstate_word;
        end
        ECG_IDX_IRQ_STATUS: begin
          st_nxt.rdata[ECG_IRQ_W-1:0] = st_r.irq_status;
        end
        ECG_IDX_IRQ_MASK: begin
          st_nxt.rdata[ECG_IRQ_W-1:0] = st_r.irq_mask;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // A new event beats a write-one-to-clear in the same cycle
    st_nxt.irq_status = (st_r.irq_status & ~irq_clr) | irq_set;
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
  end

  // ==================================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.power_enable <= ECG_CTRL_RESET[ECG_POWER_ENABLE_POS];
      st_r.lock_now <= ECG_OPSTATE_RESET[ECG_OPS_LOCK_NOW];
      st_r.busy <= ECG_OPSTATE_RESET[ECG_OPS_BUSY];
      st_r.int_fault <= ECG_OPSTATE_RESET[ECG_OPS_INT_FAULT];
      st_r.irq_mask <= ECG_IRQ_MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==================================================================
  // Outputs, all straight from the state register
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign power_enable_bit = st_r.power_enable;
  assign irq = st_r.irq;

endmodule // ecg_status_regs

`default_nettype wire

//--- testbench/ecg_status_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bus and status word checks
module ecg_status_properties
  import ecg_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ECG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Address of the read in flight, so the answer can be judged by register
  logic [ECG_ADDR_W-1:0] ar_q_r;
  always_ff @(posedge sys_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q_r <= s_axi_araddr;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  wr_answer_a: assert property (s_axi_bvalid == 1'h0 && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  ops_reserved_a: assert property ($rose(s_axi_rvalid) && ar_q_r == 8'h7c |-> s_axi_rdata[31:4] == 28'h0)
    else $error("state word reserved bits set");
  range_reserved_a: assert property ($rose(s_axi_rvalid) && ar_q_r == 8'h78
    |-> s_axi_rdata[31:24] == 8'h0 && s_axi_rdata[17:14] == 4'h0 && s_axi_rdata[6:3] == 4'h0
    && s_axi_rdata[1:0] == 2'h0) else $error("range word reserved bits set");
endmodule // ecg_status_properties
bind ecg_status_regs ecg_status_properties chk_i (.*);
`default_nettype wire

//--- testbench/lead_off_and_operating_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lead_off_and_operating_status_tb;
  import ecg_status_pkg::*;
  logic sys_clk = 1'h0, reset_n = 1'h0;
  logic [ECG_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, power_enable_bit, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] over_cmp = 7'h0, under_cmp = 7'h0;
  logic pll_locked = 1'h1, internal_error = 1'h0, config_loaded = 1'h0;
  int mismatches = 0, checks_done = 0, cyc = 0, lost = 0, fault = 0;
  ecg_status_regs dut (.*);
  initial forever #2 sys_clk = ~sys_clk;
  // Bench cycles are under two hundred; the ceiling leaves a wide margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end
  // ==========
  // Reference model and bus tasks
  function automatic logic [31:0] ops();
    return {28'h0, 1'(fault), ~config_loaded, 1'(lost), pll_locked};
  endfunction
  function automatic logic [31:0] rng(input logic [6:0] o, input logic [6:0] u);
    return {8'h0, o[6:1], 4'h0, o[0], u[6:1], 4'h0, u[0], 2'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    // Late ready keeps the response waiting a cycle
    s_axi_bready <= 1'h1;
    @(posedge sys_clk);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    @(posedge sys_clk);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Extra edge lets input changes land before the expectation is formed
  task automatic rd_ops();
    @(posedge sys_clk);
    rd_chk(8'h7c, ops(), ECG_RESP_OKAY);
    lost = 0;
  endtask
  task automatic rd_rng();
    @(posedge sys_clk);
    rd_chk(8'h78, rng(over_cmp, under_cmp), ECG_RESP_OKAY);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  initial begin
    void'($urandom(15532));
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'h1;
    rd_ops();
    config_loaded <= 1'h1;
    rd_ops();
    for (int i = 0; i < 8; i++) begin
      over_cmp <= (i == 0) ? 7'h7f : 7'($urandom);
      under_cmp <= (i == 0) ? 7'h7f : 7'($urandom);
      rd_rng();
    end
    wr(8'h78, 32'hffffffff, ECG_RESP_OKAY);
    rd_rng();
    wr(8'h04, 32'h2, ECG_RESP_OKAY);
    chk({31'h0, power_enable_bit}, 32'h1);
    pll_locked <= 1'h0;
    lost = 1;
    rd_ops();
    rd_ops();
    pll_locked <= 1'h1;
    repeat (3) @(posedge sys_clk);
    pll_locked <= 1'h0;
    repeat (3) @(posedge sys_clk);
    wr(8'h04, 32'h0, ECG_RESP_OKAY);
    rd_ops();
    pll_locked <= 1'h1;
    wr(8'hc4, 32'h0, ECG_RESP_OKAY);
    // Lock loss, ready and a rising range flag have all been seen by now; no fault yet
    rd_chk(8'hc0, 32'hd, ECG_RESP_OKAY);
    wr(8'hc0, 32'hf, ECG_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    internal_error <= 1'h1;
    @(posedge sys_clk);
    internal_error <= 1'h0;
    fault = 1;
    rd_ops();
    chk({31'h0, irq}, 32'h0);
    wr(8'hc4, 32'h2, ECG_RESP_OKAY);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(8'hc0, 32'h2, ECG_RESP_OKAY);
    wr(8'hc0, 32'h2, ECG_RESP_OKAY);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h7c, 32'hffffffff, ECG_RESP_OKAY);
    rd_ops();
    rd_chk(8'h80, 32'h0, ECG_RESP_SLVERR);
    wr(8'h80, 32'h1, ECG_RESP_SLVERR);
    // Reset in mid-run drops the sticky fault and the mask
    reset_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    fault = 0;
    lost = 0;
    rd_ops();
    rd_chk(8'hc4, 32'h0, ECG_RESP_OKAY);
    final_report();
  end
endmodule // lead_off_and_operating_status_tb
`default_nettype wire
